/* rtl/fifo_host_pkg.sv */
// constants shared by the shift-register fifo host controller
// assumes one 200 MHz core clock; the device pins are asynchronous to it
//
// Behaviour
// (RL1) device raises input-ready when input stage vacant
// (RL2) shift-in rise captures word, input-ready drops
// (RL3) input-ready returns once input stage frees
// (RL4) strobe low lets word ripple toward output
// (RL5) writer repeats handshake per word, sixteen max
// (RL6) full device keeps input-ready low, ignores shift-in
// (RL7) shift-out while full starts vacancy bubbling up
// (RL8) shift-in held while full auto-loads on vacancy
// (RL9) writer returns shift-in low to finish
// (RL10) output-ready high when word valid and idle
// (RL11) shift-out rise drives output-ready low
// (RL12) shift-out low loads next word, flag returns
// (RL13) empty device keeps output-ready low
// (RL14) burst pulses beyond capacity are ignored
// (RL15) shift-out held while empty pulses output-ready
// (RL16) held shift-out: flag drops when empty again
// (RL17) reader returns shift-out low to finish
// (RL18) master clear empties store, sets flags
// (RL19) four-bit words, three-state outputs under enable
package fifo_host_pkg;

    // ****************************************************************
    // sizes
    // ****************************************************************
    localparam int WORD_W       = 4;
    localparam int DEV_DEPTH    = 16;
    localparam int CNT_W        = 4;

    // ****************************************************************
    // timing, printed figures then cycle counts (least times round up)
    // ****************************************************************
    localparam int CLK_PERIOD_PS = 5000;
    localparam int STROBE_MIN_NS = 24;
    localparam int CLEAR_MIN_NS  = 24;
    localparam int RECOVER_NS    = 22;

    localparam int STROBE_CYC_I  = (STROBE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CLEAR_CYC_I   = (CLEAR_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int RECOVER_CYC_I = (RECOVER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // counters load count minus one and wait for zero
    localparam logic [CNT_W-1:0] STROBE_LOAD  = CNT_W'(STROBE_CYC_I - 1);
    localparam logic [CNT_W-1:0] CLEAR_LOAD   = CNT_W'(CLEAR_CYC_I - 1);
    localparam logic [CNT_W-1:0] RECOVER_LOAD = CNT_W'(RECOVER_CYC_I - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO     = '0;

    // ****************************************************************
    // state types
    // ****************************************************************
    typedef enum logic [1:0] {W_IDLE, W_HIGH, W_LOW} wr_state_t;
    typedef enum logic [1:0] {R_IDLE, R_HIGH, R_LOW} rd_state_t;
    typedef enum logic [1:0] {C_OFF, C_PULSE, C_RECOVER} clr_state_t;

endpackage : fifo_host_pkg

/* rtl/word_buf_if.sv */
// handshake bundle between the host controller and its two-entry buffer
// assumes both ends run on the core clock
`timescale 1ns/1ps
`default_nettype none
interface word_buf_if #(parameter int W = 4);
    logic         push_valid;
    logic         push_ready;
    logic [W-1:0] push_data;
    logic         pop_valid;
    logic         pop_ready;
    logic [W-1:0] pop_data;

    modport store (input push_valid, push_data, pop_ready,
                   output push_ready, pop_valid, pop_data);
    modport user  (output push_valid, push_data, pop_ready,
                   input push_ready, pop_valid, pop_data);
endinterface : word_buf_if
`default_nettype wire

/* rtl/word_buf2.sv */
// two-entry valid/ready buffer, read data from a register
// assumes push and pop sides on the same clock, synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module word_buf2 #(
    parameter int W = 4
) (
    input  wire logic   clk,
    input  wire logic   rst_n,
    word_buf_if.store   bus
);

    // ****************************************************************
    // storage and pointers
    // ****************************************************************
    logic [W-1:0] mem_q [2];
    logic [W-1:0] mem_d [2];
    logic         wp_q, wp_d;
    logic         rp_q, rp_d;
    logic [1:0]   cnt_q, cnt_d;
    logic         push_fire, pop_fire;

    // honest full and empty straight from the count
    assign bus.push_ready = (cnt_q != 2'h2);
    assign bus.pop_valid  = (cnt_q != 2'h0);
    assign bus.pop_data   = mem_q[rp_q];
    assign push_fire      = bus.push_valid && bus.push_ready;
    assign pop_fire       = bus.pop_valid && bus.pop_ready;

    // next pointers, count and contents
    always_comb begin
        mem_d = mem_q;
        wp_d  = wp_q;
        rp_d  = rp_q;
        cnt_d = cnt_q;
        if (push_fire) begin
            mem_d[wp_q] = bus.push_data;
            wp_d        = ~wp_q;
        end
        if (pop_fire) begin
            rp_d = ~rp_q;
        end
        if (push_fire && !pop_fire) begin
            cnt_d = cnt_q + 2'h1;
        end else if (pop_fire && !push_fire) begin
            cnt_d = cnt_q - 2'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mem_q[0] <= '0;
            mem_q[1] <= '0;
            wp_q     <= 1'b0;
            rp_q     <= 1'b0;
            cnt_q    <= 2'h0;
        end else begin
            mem_q <= mem_d;
            wp_q  <= wp_d;
            rp_q  <= rp_d;
            cnt_q <= cnt_d;
        end
    end

endmodule : word_buf2
`default_nettype wire

/* rtl/fifo_host.sv */
// host controller for a clockless 16-word shift-register fifo
// drives the shift strobes, master clear, data and output enable pins;
// assumes the device flags and word outputs are asynchronous to CORE_CLK
`timescale 1ns/1ps
`default_nettype none
module fifo_host (
    input  wire logic                             CORE_CLK,
    input  wire logic                             RST_N,
    // user write stream
    input  wire logic                             WR_VALID,
    output logic                                  WR_READY,
    input  wire logic [fifo_host_pkg::WORD_W-1:0] WR_DATA,
    // user read stream
    output logic                                  RD_VALID,
    input  wire logic                             RD_READY,
    output logic [fifo_host_pkg::WORD_W-1:0]      RD_DATA,
    // clear request, one pulse
    input  wire logic                             CLEAR_REQ,
    output logic                                  CLEAR_BUSY,
    // device pins
    output logic                                  SHIFT_IN,
    output logic                                  SHIFT_OUT,
    output logic                                  MASTER_CLEAR,
    output logic [fifo_host_pkg::WORD_W-1:0]      WORD_INPUTS,
    output logic                                  WORD_OUT_ENABLE,
    input  wire logic                             INPUT_READY_FLAG,
    input  wire logic                             OUTPUT_READY_FLAG,
    input  wire logic [fifo_host_pkg::WORD_W-1:0] WORD_OUTPUTS
);

    localparam int W = fifo_host_pkg::WORD_W;

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic [W-1:0] q_m_q, q_s_q;
    logic         dir_m_q, dir_s_q, dor_m_q, dor_s_q;

    // first stage is read only by the second stage
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            q_m_q   <= '0;
            q_s_q   <= '0;
            dir_m_q <= 1'b0;
            dir_s_q <= 1'b0;
            dor_m_q <= 1'b0;
            dor_s_q <= 1'b0;
        end else begin
            q_m_q   <= WORD_OUTPUTS;
            q_s_q   <= q_m_q;
            dir_m_q <= INPUT_READY_FLAG;
            dir_s_q <= dir_m_q;
            dor_m_q <= OUTPUT_READY_FLAG;
            dor_s_q <= dor_m_q;
        end
    end

    // ****************************************************************
    // master clear sequencer
    // ****************************************************************
    fifo_host_pkg::clr_state_t          c_q, c_d;
    logic [fifo_host_pkg::CNT_W-1:0]    c_cnt_q, c_cnt_d;
    logic                               clr_busy, clr_kill;

    assign clr_busy = (c_q != fifo_host_pkg::C_OFF);
    assign clr_kill = clr_busy || (CLEAR_REQ && (c_q == fifo_host_pkg::C_OFF));

    // pulse, then hold off the strobes for the recovery time
    always_comb begin
        c_d     = c_q;
        c_cnt_d = c_cnt_q;
        unique case (c_q)
            fifo_host_pkg::C_OFF: begin
                if (CLEAR_REQ) begin
                    c_d     = fifo_host_pkg::C_PULSE;
                    c_cnt_d = fifo_host_pkg::CLEAR_LOAD;
                end
            end
            fifo_host_pkg::C_PULSE: begin
                if (c_cnt_q == fifo_host_pkg::CNT_ZERO) begin
                    c_d     = fifo_host_pkg::C_RECOVER;
                    c_cnt_d = fifo_host_pkg::RECOVER_LOAD;
                end else begin
                    c_cnt_d = c_cnt_q - 1'b1;
                end
            end
            fifo_host_pkg::C_RECOVER: begin
                if (c_cnt_q == fifo_host_pkg::CNT_ZERO) begin
                    c_d = fifo_host_pkg::C_OFF;
                end else begin
                    c_cnt_d = c_cnt_q - 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            c_q     <= fifo_host_pkg::C_OFF;
            c_cnt_q <= '0;
        end else begin
            c_q     <= c_d;
            c_cnt_q <= c_cnt_d;
        end
    end

    // ****************************************************************
    // shift-in writer
    // ****************************************************************
    fifo_host_pkg::wr_state_t           w_q, w_d;
    logic [fifo_host_pkg::CNT_W-1:0]    w_cnt_q, w_cnt_d;
    logic                               w_seen_q, w_seen_d;
    logic [W-1:0]                       wdat_q, wdat_d;

    // only offer a word when the device shows a vacant input stage and no clear starts
    assign WR_READY = (w_q == fifo_host_pkg::W_IDLE) && dir_s_q && !clr_kill; // RL1 RL6

    // strobe high until capture seen, then low for the least width
    always_comb begin
        w_d      = w_q;
        w_cnt_d  = w_cnt_q;
        w_seen_d = w_seen_q;
        wdat_d   = wdat_q;
        unique case (w_q)
            fifo_host_pkg::W_IDLE: begin
                if (WR_VALID && WR_READY) begin
                    w_d      = fifo_host_pkg::W_HIGH; // RL5
                    w_cnt_d  = fifo_host_pkg::STROBE_LOAD;
                    w_seen_d = 1'b0;
                    wdat_d   = WR_DATA;
                end
            end
            fifo_host_pkg::W_HIGH: begin
                w_seen_d = w_seen_q || !dir_s_q; // RL2
                if (w_cnt_q != fifo_host_pkg::CNT_ZERO) begin
                    w_cnt_d = w_cnt_q - 1'b1;
                end else if (w_seen_q) begin
                    w_d     = fifo_host_pkg::W_LOW; // RL9
                    w_cnt_d = fifo_host_pkg::STROBE_LOAD;
                end
            end
            fifo_host_pkg::W_LOW: begin
                if (w_cnt_q == fifo_host_pkg::CNT_ZERO) begin
                    w_d = fifo_host_pkg::W_IDLE;
                end else begin
                    w_cnt_d = w_cnt_q - 1'b1;
                end
            end
            default: w_d = fifo_host_pkg::W_IDLE;
        endcase
        if (clr_kill) begin
            w_d = fifo_host_pkg::W_IDLE; // RL18
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            w_q      <= fifo_host_pkg::W_IDLE;
            w_cnt_q  <= '0;
            w_seen_q <= 1'b0;
            wdat_q   <= '0;
        end else begin
            w_q      <= w_d;
            w_cnt_q  <= w_cnt_d;
            w_seen_q <= w_seen_d;
            wdat_q   <= wdat_d;
        end
    end

    // ****************************************************************
    // shift-out reader and buffer
    // ****************************************************************
    fifo_host_pkg::rd_state_t           r_q, r_d;
    logic [fifo_host_pkg::CNT_W-1:0]    r_cnt_q, r_cnt_d;
    logic                               r_seen_q, r_seen_d;
    logic                               push_fire;

    word_buf_if #(.W(W)) bif ();

    word_buf2 #(.W(W)) u_buf (
        .clk   (CORE_CLK),
        .rst_n (RST_N),
        .bus   (bif.store)
    );

    // word is stable while the flag is high; both pass equal sync depth
    assign bif.push_valid = (r_q == fifo_host_pkg::R_IDLE) && dor_s_q && !clr_kill; // RL10
    assign bif.push_data  = q_s_q;
    assign bif.pop_ready  = RD_READY;
    assign push_fire      = bif.push_valid && bif.push_ready;
    assign RD_VALID       = bif.pop_valid;
    assign RD_DATA        = bif.pop_data;

    // a full buffer stalls the unload, so the device simply holds the word
    always_comb begin
        r_d      = r_q;
        r_cnt_d  = r_cnt_q;
        r_seen_d = r_seen_q;
        unique case (r_q)
            fifo_host_pkg::R_IDLE: begin
                if (push_fire) begin
                    r_d      = fifo_host_pkg::R_HIGH;
                    r_cnt_d  = fifo_host_pkg::STROBE_LOAD;
                    r_seen_d = 1'b0;
                end
            end
            fifo_host_pkg::R_HIGH: begin
                r_seen_d = r_seen_q || !dor_s_q; // RL11
                if (r_cnt_q != fifo_host_pkg::CNT_ZERO) begin
                    r_cnt_d = r_cnt_q - 1'b1;
                end else if (r_seen_q) begin
                    r_d     = fifo_host_pkg::R_LOW; // RL17
                    r_cnt_d = fifo_host_pkg::STROBE_LOAD;
                end
            end
            fifo_host_pkg::R_LOW: begin
                // flag sync lag is shorter than this wait, RL12 RL13
                if (r_cnt_q == fifo_host_pkg::CNT_ZERO) begin
                    r_d = fifo_host_pkg::R_IDLE;
                end else begin
                    r_cnt_d = r_cnt_q - 1'b1;
                end
            end
            default: r_d = fifo_host_pkg::R_IDLE;
        endcase
        if (clr_kill) begin
            r_d = fifo_host_pkg::R_IDLE;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            r_q      <= fifo_host_pkg::R_IDLE;
            r_cnt_q  <= '0;
            r_seen_q <= 1'b0;
        end else begin
            r_q      <= r_d;
            r_cnt_q  <= r_cnt_d;
            r_seen_q <= r_seen_d;
        end
    end

    // ****************************************************************
    // pin drive, decoded from registers except output enable, which follows RST_N
    // ****************************************************************
    assign SHIFT_IN        = (w_q == fifo_host_pkg::W_HIGH);
    assign SHIFT_OUT       = (r_q == fifo_host_pkg::R_HIGH);
    assign MASTER_CLEAR    = (c_q == fifo_host_pkg::C_PULSE); // RL18
    assign CLEAR_BUSY      = clr_busy;
    assign WORD_INPUTS     = wdat_q;
    assign WORD_OUT_ENABLE = RST_N; // RL19

    // ****************************************************************
    // checks
    // ****************************************************************
    AST_SI_HIGH_WIDTH: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // RL5
        $rose(SHIFT_IN) |-> (SHIFT_IN || clr_busy)[*5])
        else $error("shift-in high shorter than least width");

    AST_SI_LOW_WIDTH: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // RL9
        $fell(SHIFT_IN) |-> (!SHIFT_IN)[*5])
        else $error("shift-in low shorter than least width");

    AST_SI_WAITS_CAPTURE: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // RL9
        ($fell(SHIFT_IN) && !$past(clr_kill)) |-> $past(w_seen_q))
        else $error("shift-in dropped before capture was seen");

    AST_SI_NOT_FULL: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // RL14
        $rose(SHIFT_IN) |-> $past(dir_s_q))
        else $error("shift-in raised while device showed full");

    AST_SO_HIGH_WIDTH: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // RL17
        $rose(SHIFT_OUT) |-> (SHIFT_OUT || clr_busy)[*5])
        else $error("shift-out high shorter than least width");

    AST_SO_LOW_WIDTH: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // RL17
        $fell(SHIFT_OUT) |-> (!SHIFT_OUT)[*5])
        else $error("shift-out low shorter than least width");

    AST_SO_HAS_ROOM: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // RL10
        $rose(SHIFT_OUT) |-> $past(push_fire))
        else $error("shift-out raised without a buffered word");

    AST_CLEAR_PULSE: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // RL18
        $rose(MASTER_CLEAR) |-> (MASTER_CLEAR && !SHIFT_IN && !SHIFT_OUT)[*5]
            ##1 (!MASTER_CLEAR && !SHIFT_IN)[*5])
        else $error("master clear width or recovery violated");

endmodule : fifo_host
`default_nettype wire

/* tb/fifo_dev_model.sv */
// behavioural model of the 16-word shift-register fifo device
// assumes host strobes; flags answer after a ripple delay, long when slow is set
`timescale 1ns/1ps
`default_nettype none
module fifo_dev_model (
    input  wire logic       shift_in,
    input  wire logic       shift_out,
    input  wire logic       master_clear,
    input  wire logic [3:0] word_inputs,
    input  wire logic       out_enable,
    input  wire logic       slow,
    output logic            input_ready,
    output logic            output_ready,
    output logic [3:0]      word_outputs
);
    // ****************************************************************
    // store and flags
    // ****************************************************************
    logic [3:0] q[$];
    logic [3:0] held;
    logic [3:0] stage;
    logic       taken;
    logic       busy;
    int         dly;

    // flags low until the first clear: power-up state is unknown
    initial begin
        input_ready = 1'b0;
        output_ready = 1'b0;
        stage = 4'h0;
        taken = 1'b0;
        busy = 1'b0;
    end
    assign dly = slow ? 150 : 20;
    // released pins show the inverse, so a stale value never passes
    assign word_outputs = out_enable ? stage : ~stage;

    // master clear empties the store
    always @(posedge master_clear) begin
        q.delete();
        taken = 1'b0;
        busy = 1'b0;
        input_ready = 1'b1;
        output_ready = 1'b0;
    end

    // capture on the rising shift-in, refused when full
    always @(posedge shift_in) begin
        if (!master_clear && input_ready && q.size() < 16) begin
            held = word_inputs;
            taken = 1'b1;
            input_ready = 1'b0;
            #(dly) input_ready = (q.size() + int'(taken) < 16);
        end
    end

    // ripple toward the output once shift-in returns low
    always @(negedge shift_in) begin
        if (taken) begin
            taken = 1'b0;
            q.push_back(held);
            if (q.size() == 1 && !busy) begin
                #(dly);
                // a clear during the ripple leaves nothing to show
                if (q.size() > 0) begin
                    stage = q[0];
                    #2 output_ready = 1'b1;
                    if (shift_out) begin
                        busy = 1'b1;
                        #5 output_ready = 1'b0;
                    end
                end
            end
        end
    end

    // shift-out rise marks the output stage busy
    always @(posedge shift_out) begin
        if (output_ready) begin
            busy = 1'b1;
            output_ready = 1'b0;
        end
    end

    // shift-out fall unloads, bubbles a vacancy and loads the next word
    always @(negedge shift_out) begin
        if (busy) begin
            if (q.size() > 0) void'(q.pop_front());
            #(dly);
            if (!taken) begin
                input_ready = 1'b1;
                // held shift-in takes the vacancy at once
                if (shift_in && !master_clear) begin
                    held = word_inputs;
                    taken = 1'b1;
                    #5 input_ready = 1'b0;
                end
            end
            busy = 1'b0;
            if (q.size() > 0) begin
                stage = q[0];
                #2 output_ready = 1'b1;
            end // empty store: flag stays low
        end
    end
endmodule : fifo_dev_model
`default_nettype wire

/* tb/fifo_host_bench.sv */
// self-checking bench for the fifo host controller and a device model
// assumes the 200 MHz core clock and the synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module fifo_host_bench;
    // ****************************************************************
    // signals and instances
    // ****************************************************************
    logic       clk, rst_n, wr_valid, wr_ready, rd_valid, rd_ready;
    logic       clear_req, clear_busy, si, so, mc, oe, ir, orf, slow_dev;
    logic [3:0] wr_data, rd_data, word_in, word_out;
    int         num_errors, total_checks;

    fifo_host fifo_host_inst (
        .CORE_CLK(clk), .RST_N(rst_n), .WR_VALID(wr_valid), .WR_READY(wr_ready),
        .WR_DATA(wr_data), .RD_VALID(rd_valid), .RD_READY(rd_ready), .RD_DATA(rd_data),
        .CLEAR_REQ(clear_req), .CLEAR_BUSY(clear_busy), .SHIFT_IN(si), .SHIFT_OUT(so),
        .MASTER_CLEAR(mc), .WORD_INPUTS(word_in), .WORD_OUT_ENABLE(oe),
        .INPUT_READY_FLAG(ir), .OUTPUT_READY_FLAG(orf), .WORD_OUTPUTS(word_out));

    fifo_dev_model fifo_dev_model_inst (
        .shift_in(si), .shift_out(so), .master_clear(mc), .word_inputs(word_in),
        .out_enable(oe), .slow(slow_dev), .input_ready(ir), .output_ready(orf),
        .word_outputs(word_out));

    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic check(input logic [3:0] seen, input logic [3:0] exp, input string msg);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check

    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : final_report

    // offer one word; held until ready is seen, or the bound runs out
    task automatic put_word(input logic [3:0] d, input int bound, output logic ok);
        int n;
        n = 0;
        ok = 1'b0;
        @(posedge clk);
        wr_valid <= 1'b1;
        wr_data <= d;
        while (!ok && n < bound) begin
            @(negedge clk);
            ok = (wr_ready === 1'b1);
            n++;
        end
        @(posedge clk);
        wr_valid <= 1'b0;
    endtask : put_word

    task automatic send(input logic [3:0] d);
        logic ok;
        put_word(d, 400, ok);
        check(ok, 1'b1, "write taken");
        if (!ok) final_report();
        @(negedge clk);
        @(negedge clk);
        check(si, 1'b1, "shift-in strobe");
        check(word_in, d, "word inputs");
    endtask : send

    task automatic get_word(input logic [3:0] exp);
        int n;
        logic v;
        n = 0;
        @(posedge clk);
        rd_ready <= 1'b1;
        do begin
            @(negedge clk);
            n++;
            v = rd_valid;
        end while (v !== 1'b1 && n < 400);
        check(v, 1'b1, "read valid");
        check(rd_data, exp, "read word");
        @(posedge clk);
        rd_ready <= 1'b0;
        if (v !== 1'b1) final_report();
    endtask : get_word

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_clear();
        int nm, nb;
        nm = 0;
        nb = 0;
        @(posedge clk);
        clear_req <= 1'b1;
        @(posedge clk);
        clear_req <= 1'b0;
        repeat (16) begin
            @(negedge clk);
            nm += int'(mc === 1'b1);
            nb += int'(clear_busy === 1'b1);
            if (clear_busy === 1'b1) check(si, 1'b0, "strobe in clear");
            if (clear_busy === 1'b1) check(so, 1'b0, "unload in clear");
        end
        check(4'(nm), 4'h5, "clear pulse width");
        check(4'(nb), 4'hA, "clear busy width");
        check(ir, 1'b1, "input ready after clear");
        check(orf, 1'b0, "output ready after clear");
        $display("test clear done");
    endtask : t_clear

    task automatic t_one(input logic s, input logic [3:0] d);
        slow_dev = s;
        send(d);
        get_word(d);
        slow_dev = 1'b0;
        $display("test single word done");
    endtask : t_one

    // fill device and buffer, expect refusal, then drain in order
    task automatic t_fill();
        logic ok;
        for (int i = 0; i < 18; i++) send(4'(i));
        put_word(4'hF, 300, ok);
        check(ok, 1'b0, "write into full store");
        check(ir, 1'b0, "input ready when full");
        for (int i = 0; i < 18; i++) get_word(4'(i));
        repeat (100) @(negedge clk);
        check(rd_valid, 1'b0, "nothing left");
        check(orf, 1'b0, "output ready when empty");
        $display("test fill and drain done");
    endtask : t_fill

    // clear empties the device; the two buffered words survive
    task automatic t_clear_keep();
        int n;
        n = 0;
        send(4'h3);
        send(4'hC);
        send(4'h6);
        while (orf !== 1'b1 && n < 300) begin
            @(negedge clk);
            n++;
        end
        check(orf, 1'b1, "third word held in device");
        t_clear();
        get_word(4'h3);
        get_word(4'hC);
        repeat (100) @(negedge clk);
        check(rd_valid, 1'b0, "cleared word gone");
        $display("test clear with data done");
    endtask : t_clear_keep

    // ****************************************************************
    // clock and main sequence
    // ****************************************************************
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        num_errors = 0;
        total_checks = 0;
        rst_n = 1'b0;
        wr_valid = 1'b0;
        rd_ready = 1'b0;
        clear_req = 1'b0;
        wr_data = 4'h0;
        slow_dev = 1'b0;
        repeat (20) @(posedge clk);
        check(oe, 1'b0, "output enable in reset");
        rst_n <= 1'b1;
        @(negedge clk);
        @(negedge clk);
        check(oe, 1'b1, "output enable after reset");
        t_clear();
        t_one(1'b0, 4'hA);
        t_one(1'b1, 4'h5);
        t_fill();
        t_clear_keep();
        final_report();
    end
endmodule : fifo_host_bench
`default_nettype wire
